// [fsu_pkg.sv]
// constants, types and register map of the frame state and register update control core
// Contract
// [RL1] uncategorised registers take effect on write
// [RL2] frame-aligned values shadowed, loaded at global sample
// [RL3] host edits context registers only when inactive
// [RL4] host edits idle-only registers in idle/soft reset
// [RL5] host edits soft-reset-only registers under soft reset
// [RL6] writes to read-only registers are discarded
// [RL7] reads allowed; frame-aligned reads return last written
// [RL8] bypass bit makes frame-aligned writes immediate
// [RL9] upload hold bit suppresses frame-start transfer
// [RL10] host holds upload during multi-register updates
// [RL11] soft reset bit low holds sensor reset
// [RL12] hard reset pin clears everything
// [RL13] soft reset spares serial port and registers
// [RL14] five frame states: reset idle exposure sample readout
// [RL15] sequential: exposure, sample, readout, then idle
// [RL16] pipelined: next exposure overlaps current readout
// [RL17] leaving idle starts exposure, sample, readout
// [RL18] readout end without new exposure returns idle
// [RL19] readout end with exposure: wait, then sample
// [RL20] upload hold release starts new frame early
// [RL21] live and access context selects, 0=A 1=B
// [RL22] soft reset keeps frame machine out, then idle
package fsu_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] ADDR_LIVE_CTX = 7'h02;
    localparam logic [6:0] ADDR_ACC_CTX = 7'h03;
    localparam logic [6:0] ADDR_HOLD = 7'h04;
    localparam logic [6:0] ADDR_BYPASS = 7'h05;
    localparam logic [6:0] ADDR_SOFT_RST = 7'h06;
    localparam logic [6:0] ADDR_ROW_WIN = 7'h07;
    localparam logic [6:0] ADDR_STATUS = 7'h08;
    localparam logic [6:0] ADDR_EXP_LEN = 7'h09;
    localparam logic [6:0] ADDR_PIPE_EN = 7'h0a;

    localparam int CTRL_BIT = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_CTX = 8'h00;
    localparam logic RST_HOLD = 1'b0;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic RST_SOFT_RST_N = 1'b1;
    localparam logic [7:0] RST_ROW_WIN = 8'h00;
    localparam logic [7:0] RST_EXP_LEN = 8'h01;
    localparam logic RST_PIPE_EN = 1'b0;

    // ****************************************
    // serial frame and timing counts
    // ****************************************
    localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
    localparam logic [4:0] SPI_DATA_LAST = 5'h0f;
    localparam logic [15:0] GLOBAL_SAMPLE_STATE_CYCLES = 16'h0010;
    localparam logic [15:0] ROW_CYCLES = 16'h0008;
    localparam logic [15:0] EXP_UNIT = 16'h0010;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_EXPOSURE,
        ST_GLOBAL_SAMPLE,
        ST_READOUT
    } fsu_state_e;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } fsu_spi_in_s;

    typedef struct packed {
        logic in_reset;
        logic idle;
        logic exposing;
        logic sampling;
        logic reading;
    } fsu_status_s;

endpackage : fsu_pkg

// [fsu_ctrl.sv]
// frame state machine, serial register bank and frame-aligned update control
`timescale 1ns/1ps
module fsu_ctrl (
    // clock and hard reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // serial register port
    input wire fsu_pkg::fsu_spi_in_s spi_i,
    output logic spi_miso,
    output logic spi_miso_oe,
    // exposure request pin
    input wire logic exp_req,
    // frame status
    output fsu_pkg::fsu_status_s status,
    output logic [7:0] row_window_setting
);

    // ****************************************
    // serial port and register bank
    // ****************************************
    logic sclk_q_r, sclk_q_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [7:0] rd_sh_r, rd_sh_nxt;
    logic rd_mode_r, rd_mode_nxt;
    logic miso_r, miso_nxt;
    logic miso_oe_r, miso_oe_nxt;
    logic [7:0] live_ctx_r, live_ctx_nxt;
    logic [7:0] acc_ctx_r, acc_ctx_nxt;
    logic hold_r, hold_nxt;
    logic bypass_r, bypass_nxt;
    logic soft_rst_n_r, soft_rst_n_nxt;
    logic [7:0] row_win_wr_r, row_win_wr_nxt;
    logic [7:0] exp_len_r [2];
    logic [7:0] exp_len_nxt [2];
    logic pipe_en_r, pipe_en_nxt;

    logic sclk_rise, sclk_fall;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;

    // frame group state; state and exposure flags read back through the bank
    fsu_pkg::fsu_state_e st_r, st_nxt;
    logic [7:0] row_win_work_r, row_win_work_nxt;
    logic exp_busy_r, exp_busy_nxt;
    logic exp_done_r, exp_done_nxt;

    function automatic logic [7:0] rd_val(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            fsu_pkg::ADDR_LIVE_CTX: v = live_ctx_r;
            fsu_pkg::ADDR_ACC_CTX: v = acc_ctx_r;
            fsu_pkg::ADDR_HOLD: v = {7'h00, hold_r};
            fsu_pkg::ADDR_BYPASS: v = {7'h00, bypass_r};
            fsu_pkg::ADDR_SOFT_RST: v = {7'h00, soft_rst_n_r};
            // [RL7] last written value
            fsu_pkg::ADDR_ROW_WIN: v = row_win_wr_r;
            fsu_pkg::ADDR_STATUS: v = {3'h0, st_r, exp_busy_r, exp_done_r};
            fsu_pkg::ADDR_EXP_LEN: v = exp_len_r[acc_ctx_r[0]];
            fsu_pkg::ADDR_PIPE_EN: v = {7'h00, pipe_en_r};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_val

    assign sclk_rise = spi_i.sclk & ~sclk_q_r & ~spi_i.cs_n;
    assign sclk_fall = ~spi_i.sclk & sclk_q_r & ~spi_i.cs_n;
    // first bit high marks a write; address then data, msb first
    assign wr_stb = sclk_rise && (bit_cnt_r == fsu_pkg::SPI_DATA_LAST) && sh_r[14];
    assign wr_addr = sh_r[13:7];
    assign wr_data = {sh_r[6:0], spi_i.mosi};

    always_comb begin
        sclk_q_nxt = spi_i.sclk;
        bit_cnt_nxt = bit_cnt_r;
        sh_nxt = sh_r;
        rd_sh_nxt = rd_sh_r;
        rd_mode_nxt = rd_mode_r;
        miso_nxt = miso_r;
        miso_oe_nxt = miso_oe_r;
        live_ctx_nxt = live_ctx_r;
        acc_ctx_nxt = acc_ctx_r;
        hold_nxt = hold_r;
        bypass_nxt = bypass_r;
        soft_rst_n_nxt = soft_rst_n_r;
        row_win_wr_nxt = row_win_wr_r;
        exp_len_nxt = exp_len_r;
        pipe_en_nxt = pipe_en_r;
        if (spi_i.cs_n) begin
            bit_cnt_nxt = 5'h00;
            rd_mode_nxt = 1'b0;
            miso_oe_nxt = 1'b0;
            miso_nxt = 1'b0;
        end else begin
            if (sclk_rise) begin
                sh_nxt = {sh_r[14:0], spi_i.mosi};
                bit_cnt_nxt = bit_cnt_r + 5'h01;
                // [RL7] reads always served
                if (bit_cnt_r == fsu_pkg::SPI_ADDR_LAST && !sh_r[6]) begin
                    rd_mode_nxt = 1'b1;
                    rd_sh_nxt = rd_val({sh_r[5:0], spi_i.mosi});
                end
            end
            if (sclk_fall && rd_mode_r) begin
                miso_oe_nxt = 1'b1;
                miso_nxt = rd_sh_r[7];
                rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
            end
        end
        // [RL1] plain registers act at once
        if (wr_stb) begin
            case (wr_addr)
                fsu_pkg::ADDR_LIVE_CTX: live_ctx_nxt = wr_data;
                fsu_pkg::ADDR_ACC_CTX: acc_ctx_nxt = wr_data;
                fsu_pkg::ADDR_HOLD: hold_nxt = wr_data[fsu_pkg::CTRL_BIT];
                fsu_pkg::ADDR_BYPASS: bypass_nxt = wr_data[fsu_pkg::CTRL_BIT];
                // [RL11] soft reset, active low
                fsu_pkg::ADDR_SOFT_RST: soft_rst_n_nxt = wr_data[fsu_pkg::CTRL_BIT];
                fsu_pkg::ADDR_ROW_WIN: row_win_wr_nxt = wr_data;
                // [RL3] host keeps to inactive context
                fsu_pkg::ADDR_EXP_LEN: exp_len_nxt[acc_ctx_r[0]] = wr_data;
                // [RL4] idle-only, host keeps to it
                fsu_pkg::ADDR_PIPE_EN: pipe_en_nxt = wr_data[fsu_pkg::CTRL_BIT];
                // [RL6] status and unmapped ignore writes
                default: ;
            endcase
        end
    end

    // [RL12] hard reset clears port and bank
    // [RL13] soft reset never touches this group
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            sh_r <= 16'h0000;
            rd_sh_r <= 8'h00;
            rd_mode_r <= 1'b0;
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
            live_ctx_r <= fsu_pkg::RST_CTX;
            acc_ctx_r <= fsu_pkg::RST_CTX;
            hold_r <= fsu_pkg::RST_HOLD;
            bypass_r <= fsu_pkg::RST_BYPASS;
            soft_rst_n_r <= fsu_pkg::RST_SOFT_RST_N;
            row_win_wr_r <= fsu_pkg::RST_ROW_WIN;
            exp_len_r[0] <= fsu_pkg::RST_EXP_LEN;
            exp_len_r[1] <= fsu_pkg::RST_EXP_LEN;
            pipe_en_r <= fsu_pkg::RST_PIPE_EN;
        end else begin
            sclk_q_r <= sclk_q_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sh_r <= sh_nxt;
            rd_sh_r <= rd_sh_nxt;
            rd_mode_r <= rd_mode_nxt;
            miso_r <= miso_nxt;
            miso_oe_r <= miso_oe_nxt;
            live_ctx_r <= live_ctx_nxt;
            acc_ctx_r <= acc_ctx_nxt;
            hold_r <= hold_nxt;
            bypass_r <= bypass_nxt;
            soft_rst_n_r <= soft_rst_n_nxt;
            row_win_wr_r <= row_win_wr_nxt;
            exp_len_r <= exp_len_nxt;
            pipe_en_r <= pipe_en_nxt;
        end
    end

    assign spi_miso = miso_r;
    assign spi_miso_oe = miso_oe_r;

    // ****************************************
    // frame state machine
    // ****************************************
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] exp_cnt_r, exp_cnt_nxt;
    logic req_q_r, req_q_nxt;
    logic hold_q_r, hold_q_nxt;
    fsu_pkg::fsu_status_s status_r, status_nxt;

    logic start_req;
    logic [15:0] exp_cycles;
    logic [15:0] ro_cycles;
    logic global_sample_state_entry;

    // [RL20] hold release counts as a start request
    assign start_req = (exp_req & ~req_q_r) | (hold_q_r & ~hold_r);
    // [RL21] live context picks the exposure setting
    assign exp_cycles = 16'(exp_len_r[live_ctx_r[0]]) * fsu_pkg::EXP_UNIT;
    assign ro_cycles = (16'(row_win_work_r) + 16'h0001) * fsu_pkg::ROW_CYCLES;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        exp_cnt_nxt = exp_cnt_r;
        exp_busy_nxt = exp_busy_r;
        exp_done_nxt = exp_done_r;
        row_win_work_nxt = row_win_work_r;
        req_q_nxt = exp_req;
        hold_q_nxt = hold_r;
        global_sample_state_entry = 1'b0;
        // exposure timer runs beside the main state so it can overlap readout
        if (exp_busy_r) begin
            if (exp_cnt_r == 16'h0000) begin
                exp_busy_nxt = 1'b0;
                exp_done_nxt = 1'b1;
            end else begin
                exp_cnt_nxt = exp_cnt_r - 16'h0001;
            end
        end
        // [RL14] five states
        case (st_r)
            fsu_pkg::ST_RESET: begin
                // [RL22] release goes to idle
                st_nxt = fsu_pkg::ST_IDLE;
            end
            fsu_pkg::ST_IDLE: begin
                // [RL17] leaving idle starts exposure
                if (start_req) begin
                    st_nxt = fsu_pkg::ST_EXPOSURE;
                    exp_busy_nxt = 1'b1;
                    exp_done_nxt = 1'b0;
                    exp_cnt_nxt = exp_cycles;
                end
            end
            fsu_pkg::ST_EXPOSURE: begin
                // [RL15] exposure then global sample
                if (exp_done_r) begin
                    global_sample_state_entry = 1'b1;
                end
            end
            fsu_pkg::ST_GLOBAL_SAMPLE: begin
                if (cnt_r == 16'h0000) begin
                    st_nxt = fsu_pkg::ST_READOUT;
                    cnt_nxt = ro_cycles - 16'h0001;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            fsu_pkg::ST_READOUT: begin
                // [RL16] overlapping exposure during readout
                if (start_req && pipe_en_r && !exp_busy_r && !exp_done_r) begin
                    exp_busy_nxt = 1'b1;
                    exp_cnt_nxt = exp_cycles;
                end
                if (cnt_r == 16'h0000) begin
                    // [RL19] wait for exposure, then sample
                    if (exp_done_r) begin
                        global_sample_state_entry = 1'b1;
                    end else if (exp_busy_r) begin
                        st_nxt = fsu_pkg::ST_EXPOSURE;
                    end else begin
                        // [RL18] nothing pending, back to idle
                        st_nxt = fsu_pkg::ST_IDLE;
                    end
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: st_nxt = fsu_pkg::ST_RESET;
        endcase
        if (global_sample_state_entry) begin
            st_nxt = fsu_pkg::ST_GLOBAL_SAMPLE;
            cnt_nxt = fsu_pkg::GLOBAL_SAMPLE_STATE_CYCLES - 16'h0001;
            exp_done_nxt = 1'b0;
            // [RL2] frame-start transfer of shadow
            // [RL9] hold bit suppresses transfer
            if (!hold_r) begin
                row_win_work_nxt = row_win_wr_r;
            end
        end
        // [RL8] bypass: write lands at once, winning over the frame-start copy
        if (bypass_r && wr_stb && wr_addr == fsu_pkg::ADDR_ROW_WIN) begin
            row_win_work_nxt = wr_data;
        end
        // [RL22] soft reset holds machine in reset
        if (!soft_rst_n_r) begin
            st_nxt = fsu_pkg::ST_RESET;
            cnt_nxt = 16'h0000;
            exp_cnt_nxt = 16'h0000;
            exp_busy_nxt = 1'b0;
            exp_done_nxt = 1'b0;
        end
        status_nxt.in_reset = (st_nxt == fsu_pkg::ST_RESET);
        status_nxt.idle = (st_nxt == fsu_pkg::ST_IDLE);
        status_nxt.exposing = exp_busy_nxt;
        status_nxt.sampling = (st_nxt == fsu_pkg::ST_GLOBAL_SAMPLE);
        status_nxt.reading = (st_nxt == fsu_pkg::ST_READOUT);
    end

    // [RL12] hard reset lands in the reset state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= fsu_pkg::ST_RESET;
            cnt_r <= 16'h0000;
            exp_cnt_r <= 16'h0000;
            exp_busy_r <= 1'b0;
            exp_done_r <= 1'b0;
            row_win_work_r <= fsu_pkg::RST_ROW_WIN;
            req_q_r <= 1'b0;
            hold_q_r <= fsu_pkg::RST_HOLD;
            status_r <= '{in_reset: 1'b1, default: 1'b0};
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            exp_cnt_r <= exp_cnt_nxt;
            exp_busy_r <= exp_busy_nxt;
            exp_done_r <= exp_done_nxt;
            row_win_work_r <= row_win_work_nxt;
            req_q_r <= req_q_nxt;
            hold_q_r <= hold_q_nxt;
            status_r <= status_nxt;
        end
    end

    assign status = status_r;
    assign row_window_setting = row_win_work_r;

endmodule : fsu_ctrl

// [fsu_ctrl_props.sv]
// assertion checker for the frame state and register update control core
`timescale 1ns/1ps
module fsu_ctrl_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // serial port
    input wire fsu_pkg::fsu_spi_in_s spi_i,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    // frame control
    input wire logic exp_req,
    input wire fsu_pkg::fsu_status_s status,
    input wire logic [7:0] row_window_setting
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // frame state, hard reset and serial port checks
    // ****************************************
    a_exp_sample_excl: assert property (!(status.exposing && status.sampling))
        else $error("exposure and sample both shown");
    a_idle_alone: assert property (
        status.idle |-> !(status.exposing || status.sampling || status.reading || status.in_reset))
        else $error("idle shown with another state");
    // soft reset may cut a sample short, so it is excused
    a_sample_len: assert property (disable iff (sys_rst || status.in_reset)
        $rose(status.sampling) |-> status.sampling[*8] ##1 status.sampling[*8] ##1 !status.sampling)
        else $error("sample not sixteen cycles");
    a_sample_to_read: assert property (
        $fell(status.sampling) && !status.in_reset |-> status.reading)
        else $error("sample not followed by readout");
    a_sample_entry: assert property ($rose(status.sampling) |-> !$past(status.idle))
        else $error("sample entered from idle");
    a_idle_to_exp: assert property ($fell(status.idle) && !status.in_reset |-> status.exposing)
        else $error("idle left without exposure");
    a_read_end: assert property (
        $fell(status.reading) && !status.in_reset |->
            status.idle || status.exposing || status.sampling)
        else $error("readout ended into nothing");
    a_soft_hold: assert property (
        status.in_reset |-> !(status.exposing || status.sampling || status.reading))
        else $error("frame activity under soft reset");
    a_hard_clear: assert property ($past(sys_rst) |-> row_window_setting == 8'h00)
        else $error("row window not cleared by hard reset");
    a_miso_release: assert property (spi_i.cs_n [*3] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
endmodule : fsu_ctrl_chk

bind fsu_ctrl fsu_ctrl_chk fsu_ctrl_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_i(spi_i),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .exp_req(exp_req), .status(status),
    .row_window_setting(row_window_setting));

// [fsu_host.sv]
// host controller model: serial register port and exposure request pin
`timescale 1ns/1ps
module fsu_host (
    // clock
    input wire logic clk_sys,
    // serial port
    output fsu_pkg::fsu_spi_in_s spi_o,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    // request pin
    output logic exp_req
);
    // ****************************************
    // idle levels and transfers
    // ****************************************
    initial begin
        spi_o = 3'h2;
        exp_req = 1'b0;
    end
    // sclk at clk/6, safely below the clk/2 limit of the single-sample edge detector
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] fr;
        fr = {wr, a, wd};
        rd = 8'h00;
        @(negedge clk_sys);
        spi_o.cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_o.mosi = fr[i];
            repeat (3) @(negedge clk_sys);
            if (i < 8) rd[i] = spi_miso_oe ? spi_miso : 1'b0;
            spi_o.sclk = 1'b1;
            repeat (3) @(negedge clk_sys);
            spi_o.sclk = 1'b0;
        end
        repeat (3) @(negedge clk_sys);
        spi_o.cs_n = 1'b1;
        // released data line must not keep looking valid
        spi_o.mosi = ~spi_o.mosi;
    endtask : xfer
    task automatic request();
        @(negedge clk_sys);
        exp_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        exp_req = 1'b0;
    endtask : request
endmodule : fsu_host

// [testbench.sv]
// self-checking testbench of the frame state and register update control core
`timescale 1ns/1ps
module testbench;
    logic clk_sys;
    logic sys_rst;
    fsu_pkg::fsu_spi_in_s spi_i;
    logic spi_miso;
    logic spi_miso_oe;
    logic exp_req;
    fsu_pkg::fsu_status_s status;
    logic [7:0] row_window_setting;
    logic [4:0] st;
    int error_cnt;
    int checked;
    localparam int B_EXP = 2;
    localparam int B_SMP = 1;
    localparam int B_RD = 0;
    localparam int B_IDLE = 3;
    assign st = status;
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    fsu_ctrl fsu_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_i(spi_i),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .exp_req(exp_req), .status(status),
        .row_window_setting(row_window_setting));
    fsu_host fsu_host_inst (.clk_sys(clk_sys), .spi_o(spi_i), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .exp_req(exp_req));
    // ****************************************
    // helpers
    // ****************************************
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_byte
    task automatic chk_st(input logic [4:0] e);
        checked++;
        if (st !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, st);
        end
    endtask : chk_st
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        fsu_host_inst.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        fsu_host_inst.xfer(1'b0, a, 8'h00, r);
        chk_byte(e, r);
    endtask : rd
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        while (st[b] !== v) begin
            @(negedge clk_sys);
            n++;
            if (n > 3000) begin
                error_cnt++;
                finish_test();
            end
        end
    endtask : wait_st
    task automatic cnt_hi(input int b, output logic [7:0] n);
        n = 8'h00;
        while (st[b] === 1'b1 && n < 8'hf0) begin
            @(negedge clk_sys);
            n++;
        end
        // a phase that never ends is a hang, not a long count
        if (n >= 8'hf0) begin
            error_cnt++;
            finish_test();
        end
    endtask : cnt_hi
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rd(fsu_pkg::ADDR_HOLD, 8'h00);
        rd(fsu_pkg::ADDR_BYPASS, 8'h00);
        rd(fsu_pkg::ADDR_SOFT_RST, 8'h01);
        rd(7'h7f, 8'h00);
        wr(fsu_pkg::ADDR_STATUS, 8'hff);
        rd(fsu_pkg::ADDR_STATUS, 8'h04);
        chk_st(5'h08);
        wr(fsu_pkg::ADDR_ACC_CTX, 8'h01);
        wr(fsu_pkg::ADDR_EXP_LEN, 8'h02);
        rd(fsu_pkg::ADDR_EXP_LEN, 8'h02);
        wr(fsu_pkg::ADDR_ACC_CTX, 8'h00);
        rd(fsu_pkg::ADDR_EXP_LEN, 8'h01);
    endtask : t_regs
    task automatic t_seq();
        logic [7:0] n;
        wr(fsu_pkg::ADDR_ROW_WIN, 8'h03);
        chk_byte(8'h00, row_window_setting);
        rd(fsu_pkg::ADDR_ROW_WIN, 8'h03);
        fsu_host_inst.request();
        wait_st(B_EXP, 1'b1);
        wait_st(B_SMP, 1'b1);
        chk_byte(8'h03, row_window_setting);
        cnt_hi(B_SMP, n);
        chk_byte(8'h10, n);
        cnt_hi(B_RD, n);
        chk_byte(8'h20, n);
        chk_st(5'h08);
    endtask : t_seq
    task automatic t_ctx();
        logic [7:0] n;
        // live select 1 picks the length written through access context 1
        wr(fsu_pkg::ADDR_LIVE_CTX, 8'h01);
        fsu_host_inst.request();
        // 2*16+1 exposure cycles, 3 already gone when the request returns
        cnt_hi(B_EXP, n);
        chk_byte(8'h1e, n);
        wait_st(B_IDLE, 1'b1);
    endtask : t_ctx
    task automatic t_hold();
        // hold kept high over the whole upload
        wr(fsu_pkg::ADDR_HOLD, 8'h01);
        wr(fsu_pkg::ADDR_ROW_WIN, 8'h01);
        fsu_host_inst.request();
        wait_st(B_RD, 1'b1);
        chk_byte(8'h03, row_window_setting);
        wait_st(B_IDLE, 1'b1);
        wr(fsu_pkg::ADDR_HOLD, 8'h00);
        chk_st(5'h04);
        wait_st(B_RD, 1'b1);
        chk_byte(8'h01, row_window_setting);
        wait_st(B_IDLE, 1'b1);
    endtask : t_hold
    task automatic t_bypass();
        wr(fsu_pkg::ADDR_BYPASS, 8'h01);
        rd(fsu_pkg::ADDR_BYPASS, 8'h01);
        wr(fsu_pkg::ADDR_ROW_WIN, 8'h05);
        chk_byte(8'h05, row_window_setting);
        wr(fsu_pkg::ADDR_BYPASS, 8'h00);
    endtask : t_bypass
    task automatic t_soft();
        wr(fsu_pkg::ADDR_SOFT_RST, 8'h00);
        chk_st(5'h10);
        fsu_host_inst.request();
        repeat (30) @(negedge clk_sys);
        chk_st(5'h10);
        rd(fsu_pkg::ADDR_ROW_WIN, 8'h05);
        wr(fsu_pkg::ADDR_SOFT_RST, 8'h01);
        wait_st(B_IDLE, 1'b1);
        chk_st(5'h08);
    endtask : t_soft
    task automatic t_pipe();
        wr(fsu_pkg::ADDR_PIPE_EN, 8'h01);
        fsu_host_inst.request();
        wait_st(B_RD, 1'b1);
        fsu_host_inst.request();
        chk_st(5'h05);
        wait_st(B_RD, 1'b0);
        chk_st(5'h02);
        wait_st(B_RD, 1'b1);
        wait_st(B_IDLE, 1'b1);
    endtask : t_pipe
    task automatic t_hard();
        fsu_host_inst.request();
        wait_st(B_EXP, 1'b1);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        chk_st(5'h10);
        chk_byte(8'h00, row_window_setting);
        sys_rst = 1'b0;
        wait_st(B_IDLE, 1'b1);
        rd(fsu_pkg::ADDR_ROW_WIN, 8'h00);
        rd(fsu_pkg::ADDR_PIPE_EN, 8'h00);
    endtask : t_hard
    initial begin
        error_cnt = 0;
        checked = 0;
        sys_rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_regs();
        t_seq();
        t_ctx();
        t_hold();
        t_bypass();
        t_soft();
        t_pipe();
        t_hard();
        finish_test();
    end
endmodule : testbench
